// *** hse_pkg.sv ***
// constants, types and helper functions for the home seek and gate enable block
// assumes one 100 MHz system clock and a 32-bit APB register port
//
// How it works
// - smoothing frequency 0..2500 Hz, used in mode 7
// - frequency write stores it, read returns it
// - homing uses cruise, ramp up, ramp down rates
// - negative move length seeks counter-clockwise
// - seek runs until home condition is met
// - latch position on detection, then brake
// - after stop, move back to latched position
// - limit first: reverse to other limit, retry
// - limits on pulse and direction inputs
// - limit usage 3 frees inputs for home
// - home select: input number and L/H/F/R
// - energized input reads low, open reads high
// - analog L below, H above threshold
// - enable code 1 open, 2 closed, 3 free
// - speed change modes override enable usage
// - speed mode or fault clear forces code 3
// - one owner of gate input at a time
// - enable point 1 or 3, must be input
// - enable read returns code and point combined
// - homing status bit set while seeking

package hse_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_SEEK = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_ENABLE = 8'h08;
  localparam logic [7:0] REG_SMOOTH = 8'h0c;
  localparam logic [7:0] REG_CRUISE = 8'h10;
  localparam logic [7:0] REG_RAMP_UP = 8'h14;
  localparam logic [7:0] REG_RAMP_DN = 8'h18;
  localparam logic [7:0] REG_LENGTH = 8'h1c;
  localparam logic [7:0] REG_POS = 8'h20;
  localparam logic [7:0] REG_HOME = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h28;
  localparam logic [7:0] REG_THRESH = 8'h2c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SEEK_SEL_LSB = 0;
  localparam int SEEK_COND_LSB = 4;
  localparam int CFG_LIMIT_LSB = 0;
  localparam int CFG_MODE_LSB = 8;
  localparam int CFG_FAULT_LSB = 16;
  localparam int EN_CODE_LSB = 0;
  localparam int EN_POINT_LSB = 4;
  localparam int EN_COMB_LSB = 8;
  localparam int ST_ENABLED = 0;
  localparam int ST_INPOS = 3;
  localparam int ST_MOVING = 4;
  localparam int ST_HOMING = 10;

  // ----------------------------------------------------------------
  // codes and reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] FREQ_MAX = 12'h9c4;
  localparam logic [11:0] FREQ_RST = 12'h9c4;
  localparam logic [4:0] CM_PULSE_DIR = 5'h07;
  localparam logic [4:0] CM_SPEED_A = 5'h0d;
  localparam logic [4:0] CM_SPEED_B = 5'h0e;
  localparam logic [4:0] CM_SPEED_C = 5'h11;
  localparam logic [4:0] CM_SPEED_D = 5'h12;
  localparam logic [1:0] USE_OPEN = 2'h1;
  localparam logic [1:0] USE_CLOSED = 2'h2;
  localparam logic [1:0] USE_FREE = 2'h3;
  localparam logic [1:0] POINT_ONE = 2'h1;
  localparam logic [1:0] POINT_THREE = 2'h3;
  localparam logic [1:0] IN_ANALOG = 2'h0;
  localparam logic [1:0] IN_PULSE = 2'h1;
  localparam logic [1:0] IN_ROT = 2'h2;
  localparam logic [1:0] IN_GATE = 2'h3;
  localparam logic [1:0] COND_L = 2'h0;
  localparam logic [1:0] COND_H = 2'h1;
  localparam logic [1:0] COND_F = 2'h2;
  localparam logic [1:0] COND_R = 2'h3;
  localparam logic [7:0] DEC_TEN = 8'h0a;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int RAMP_TICK_NS = 1000;
  localparam logic [15:0] RAMP_TICK_CYC = 16'(RAMP_TICK_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_SEEK = 7'h02,
    ST_BRAKE = 7'h04,
    ST_TURN = 7'h08,
    ST_REV = 7'h10,
    ST_REVBRK = 7'h20,
    ST_RETURN = 7'h40
  } hse_state_t;

  typedef struct packed {
    logic [1:0] limit_usage;
    logic [4:0] control_mode;
    logic [1:0] fault_clear_usage;
    logic [1:0] en_usage;
    logic [1:0] en_point;
  } hse_cfg_t;

  typedef struct packed {
    logic [15:0] cruise_rate;
    logic [15:0] ramp_up_rate;
    logic [15:0] ramp_down_rate;
    logic [31:0] move_length;
  } hse_motion_t;

  function automatic logic is_speed_mode(input logic [4:0] cm);
    return (cm == CM_SPEED_A) || (cm == CM_SPEED_B) || (cm == CM_SPEED_C)
        || (cm == CM_SPEED_D);
  endfunction

  function automatic logic owns_gate(input logic [1:0] use_code);
    return (use_code == USE_OPEN) || (use_code == USE_CLOSED);
  endfunction

endpackage

// *** hse_top.sv ***
// home seek sequencer, gate enable usage and smoothing filter setting
// assumes an APB3 master on clk_sys and raw sensor pins from the machine
`timescale 1ns/1ps

module hse_top (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pulse_input,
  input wire logic rotation_sense_input,
  input wire logic gate_input,
  input wire logic [11:0] analog_input,
  input wire logic [3:0] io_point_is_input,
  output logic step_out,
  output logic dir_out,
  output logic drive_enable,
  output logic homing,
  output logic seek_done,
  output logic [11:0] smooth_freq,
  output logic smooth_active
);

  // ----------------------------------------------------------------
  // input synchronisers and edge history
  // ----------------------------------------------------------------
  logic [2:0] meta_q, sync_q, prev_q;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      meta_q <= 3'h7;
      sync_q <= 3'h7;
      prev_q <= 3'h7;
    end else begin
      meta_q <= {gate_input, rotation_sense_input, pulse_input};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  hse_pkg::hse_cfg_t cfg_q, cfg_d;
  hse_pkg::hse_motion_t mot_q, mot_d;
  hse_pkg::hse_state_t state_q, state_d;
  logic [11:0] freq_q, freq_d, thresh_q, thresh_d;
  logic [1:0] sel_q, sel_d, cond_q, cond_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d;
  logic [15:0] vel_q, vel_d, tick_q, tick_d;
  logic [15:0] acc_q, acc_d;
  logic signed [31:0] pos_q, pos_d, home_q, home_d;
  logic dir_q, dir_d, seek_dir_q, seek_dir_d;
  logic step_d, done_d, en_d, smooth_act_d;
  logic [11:0] smooth_d;

  // ----------------------------------------------------------------
  // home and limit decode
  // ----------------------------------------------------------------
  logic [2:0] rise, fall;
  logic level, hit, cw_lim, ccw_lim, fwd_lim, tick, carry;
  logic [15:0] target;

  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
  assign tick = (tick_q == hse_pkg::RAMP_TICK_CYC - 16'h0001);

  always_comb begin
    level = 1'b1;
    hit = 1'b0;
    if (sel_q == hse_pkg::IN_ANALOG) begin
      case (cond_q)
        hse_pkg::COND_L: hit = analog_input < thresh_q;
        hse_pkg::COND_H: hit = analog_input > thresh_q;
        default: hit = 1'b0;
      endcase
    end else begin
      level = sync_q[sel_q - 2'h1];
      case (cond_q)
        hse_pkg::COND_L: hit = !level;
        hse_pkg::COND_H: hit = level;
        hse_pkg::COND_F: hit = fall[sel_q - 2'h1];
        hse_pkg::COND_R: hit = rise[sel_q - 2'h1];
        default: hit = 1'b0;
      endcase
    end
  end

  // code 1 trips on a closed switch, code 2 on an open one
  always_comb begin
    cw_lim = 1'b0;
    ccw_lim = 1'b0;
    if (cfg_q.limit_usage != hse_pkg::USE_FREE) begin
      cw_lim = (cfg_q.limit_usage == hse_pkg::USE_OPEN) ? !sync_q[0] : sync_q[0];
      ccw_lim = (cfg_q.limit_usage == hse_pkg::USE_OPEN) ? !sync_q[1] : sync_q[1];
    end
    fwd_lim = dir_q ? cw_lim : ccw_lim;
  end

  // ----------------------------------------------------------------
  // apb decode and configuration
  // ----------------------------------------------------------------
  logic access, fire, wr_ok, rd_ok, start;
  logic [1:0] w_code, w_point;
  logic [31:0] rd_val;
  logic [15:0] status;
  logic [7:0] combined;

  assign access = psel && penable;
  assign fire = access && pready;
  assign w_code = pwdata[hse_pkg::EN_CODE_LSB +: 2];
  assign w_point = pwdata[hse_pkg::EN_POINT_LSB +: 2];
  assign start = fire && pwrite && wr_ok && (paddr == hse_pkg::REG_SEEK);
  assign combined = 8'({6'h00, cfg_q.en_usage} * hse_pkg::DEC_TEN) + {6'h00, cfg_q.en_point};

  always_comb begin
    status = 16'h0000;
    status[hse_pkg::ST_ENABLED] = drive_enable;
    status[hse_pkg::ST_INPOS] = (state_q == hse_pkg::ST_IDLE) && (vel_q == 16'h0000);
    status[hse_pkg::ST_MOVING] = vel_q != 16'h0000;
    status[hse_pkg::ST_HOMING] = state_q != hse_pkg::ST_IDLE;
  end

  always_comb begin
    wr_ok = 1'b1;
    rd_ok = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      hse_pkg::REG_SEEK: begin
        rd_val = 32'({cond_q, 2'h0, sel_q});
        // limit pins cannot double as home while limits are live
        wr_ok = (state_q == hse_pkg::ST_IDLE) && ((cfg_q.limit_usage == hse_pkg::USE_FREE)
            || (pwdata[hse_pkg::SEEK_SEL_LSB +: 2] == hse_pkg::IN_ANALOG)
            || (pwdata[hse_pkg::SEEK_SEL_LSB +: 2] == hse_pkg::IN_GATE));
      end
      hse_pkg::REG_CFG: rd_val = 32'({cfg_q.fault_clear_usage, 3'h0, cfg_q.control_mode,
          6'h00, cfg_q.limit_usage});
      hse_pkg::REG_ENABLE: begin
        rd_val = 32'({combined, 2'h0, cfg_q.en_point, 2'h0, cfg_q.en_usage});
        wr_ok = !hse_pkg::is_speed_mode(cfg_q.control_mode)
            && (w_code != 2'h0)
            && ((w_point == hse_pkg::POINT_ONE) || (w_point == hse_pkg::POINT_THREE))
            && io_point_is_input[w_point - 2'h1];
      end
      hse_pkg::REG_SMOOTH: begin
        rd_val = 32'(freq_q);
        wr_ok = pwdata <= 32'(hse_pkg::FREQ_MAX);
      end
      hse_pkg::REG_CRUISE: rd_val = 32'(mot_q.cruise_rate);
      hse_pkg::REG_RAMP_UP: rd_val = 32'(mot_q.ramp_up_rate);
      hse_pkg::REG_RAMP_DN: rd_val = 32'(mot_q.ramp_down_rate);
      hse_pkg::REG_LENGTH: rd_val = mot_q.move_length;
      hse_pkg::REG_POS: begin
        rd_val = pos_q;
        wr_ok = 1'b0;
      end
      hse_pkg::REG_HOME: begin
        rd_val = home_q;
        wr_ok = 1'b0;
      end
      hse_pkg::REG_STATUS: begin
        rd_val = 32'(status);
        wr_ok = 1'b0;
      end
      hse_pkg::REG_THRESH: rd_val = 32'(thresh_q);
      default: begin
        wr_ok = 1'b0;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_comb begin
    cfg_d = cfg_q;
    mot_d = mot_q;
    freq_d = freq_q;
    thresh_d = thresh_q;
    sel_d = sel_q;
    cond_d = cond_q;
    // one wait state so read data comes from a flop
    pready_d = access && !pready;
    pslverr_d = access && !pready && !(pwrite ? wr_ok : rd_ok);
    prdata_d = (access && !pready && !pwrite) ? rd_val : 32'h0000_0000;
    if (fire && pwrite && wr_ok) begin
      case (paddr)
        hse_pkg::REG_SEEK: begin
          sel_d = pwdata[hse_pkg::SEEK_SEL_LSB +: 2];
          cond_d = pwdata[hse_pkg::SEEK_COND_LSB +: 2];
        end
        hse_pkg::REG_CFG: begin
          cfg_d.limit_usage = pwdata[hse_pkg::CFG_LIMIT_LSB +: 2];
          cfg_d.control_mode = pwdata[hse_pkg::CFG_MODE_LSB +: 5];
          cfg_d.fault_clear_usage = pwdata[hse_pkg::CFG_FAULT_LSB +: 2];
          if (hse_pkg::is_speed_mode(cfg_d.control_mode)
              || hse_pkg::owns_gate(cfg_d.fault_clear_usage)) begin
            cfg_d.en_usage = hse_pkg::USE_FREE;
          end
          if (hse_pkg::is_speed_mode(cfg_d.control_mode)) begin
            cfg_d.fault_clear_usage = hse_pkg::USE_FREE;
          end
        end
        hse_pkg::REG_ENABLE: begin
          cfg_d.en_usage = w_code;
          cfg_d.en_point = w_point;
          if (hse_pkg::owns_gate(w_code)) begin
            cfg_d.fault_clear_usage = hse_pkg::USE_FREE;
          end
        end
        hse_pkg::REG_SMOOTH: freq_d = pwdata[11:0];
        hse_pkg::REG_CRUISE: mot_d.cruise_rate = pwdata[15:0];
        hse_pkg::REG_RAMP_UP: mot_d.ramp_up_rate = pwdata[15:0];
        hse_pkg::REG_RAMP_DN: mot_d.ramp_down_rate = pwdata[15:0];
        hse_pkg::REG_LENGTH: mot_d.move_length = pwdata;
        hse_pkg::REG_THRESH: thresh_d = pwdata[11:0];
        default: cfg_d = cfg_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // drive enable and smoothing outputs
  // ----------------------------------------------------------------
  always_comb begin
    en_d = 1'b1;
    if (!hse_pkg::is_speed_mode(cfg_q.control_mode)) begin
      case (cfg_q.en_usage)
        hse_pkg::USE_OPEN: en_d = (cfg_q.en_point == hse_pkg::POINT_ONE) ? sync_q[0]
            : sync_q[2];
        hse_pkg::USE_CLOSED: en_d = (cfg_q.en_point == hse_pkg::POINT_ONE) ? !sync_q[0]
            : !sync_q[2];
        default: en_d = 1'b1;
      endcase
    end
    smooth_act_d = cfg_q.control_mode == hse_pkg::CM_PULSE_DIR;
    smooth_d = smooth_act_d ? freq_q : 12'h000;
  end

  // ----------------------------------------------------------------
  // seek sequencer and motion generator
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    dir_d = dir_q;
    seek_dir_d = seek_dir_q;
    home_d = home_q;
    done_d = 1'b0;
    case (state_q)
      hse_pkg::ST_IDLE: if (start) begin
        dir_d = !mot_q.move_length[31];
        seek_dir_d = !mot_q.move_length[31];
        state_d = hse_pkg::ST_SEEK;
      end
      hse_pkg::ST_SEEK: if (hit) begin
        home_d = pos_q;
        state_d = hse_pkg::ST_BRAKE;
      end else if (fwd_lim) begin
        state_d = hse_pkg::ST_TURN;
      end
      hse_pkg::ST_TURN: if (vel_q == 16'h0000) begin
        dir_d = !seek_dir_q;
        state_d = hse_pkg::ST_REV;
      end
      hse_pkg::ST_REV: if (fwd_lim) begin
        state_d = hse_pkg::ST_REVBRK;
      end
      hse_pkg::ST_REVBRK: if (vel_q == 16'h0000) begin
        dir_d = seek_dir_q;
        state_d = hse_pkg::ST_SEEK;
      end
      hse_pkg::ST_BRAKE: if (vel_q == 16'h0000) begin
        state_d = hse_pkg::ST_RETURN;
      end
      hse_pkg::ST_RETURN: begin
        dir_d = home_q > pos_q;
        if (pos_q == home_q) begin
          state_d = hse_pkg::ST_IDLE;
          done_d = 1'b1;
        end
      end
      default: state_d = hse_pkg::ST_IDLE;
    endcase
  end

  // the return leg has no distance-based braking: it halts dead on target
  always_comb begin
    target = 16'h0000;
    if ((state_q == hse_pkg::ST_SEEK) || (state_q == hse_pkg::ST_REV)
        || (state_q == hse_pkg::ST_RETURN)) begin
      target = mot_q.cruise_rate;
    end
    tick_d = tick ? 16'h0000 : tick_q + 16'h0001;
    vel_d = vel_q;
    if (tick) begin
      if (vel_q < target) begin
        vel_d = (target - vel_q > mot_q.ramp_up_rate) ? vel_q + mot_q.ramp_up_rate
            : target;
      end else if (vel_q > target) begin
        vel_d = (vel_q - target > mot_q.ramp_down_rate) ? vel_q - mot_q.ramp_down_rate
            : target;
      end
    end
    if (done_d) begin
      vel_d = 16'h0000;
    end
    {carry, acc_d} = {1'b0, acc_q} + {1'b0, vel_q};
    step_d = carry && !((state_q == hse_pkg::ST_RETURN) && (pos_q == home_q));
    pos_d = pos_q;
    if (step_d) begin
      pos_d = dir_q ? pos_q + 32'sd1 : pos_q - 32'sd1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cfg_q <= '{limit_usage: hse_pkg::USE_FREE, control_mode: hse_pkg::CM_PULSE_DIR,
          fault_clear_usage: hse_pkg::USE_FREE, en_usage: hse_pkg::USE_FREE,
          en_point: hse_pkg::POINT_THREE};
      mot_q <= '0;
      freq_q <= hse_pkg::FREQ_RST;
      thresh_q <= 12'h000;
      sel_q <= hse_pkg::IN_GATE;
      cond_q <= hse_pkg::COND_L;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      state_q <= hse_pkg::ST_IDLE;
      dir_q <= 1'b1;
      seek_dir_q <= 1'b1;
      home_q <= 32'sd0;
      pos_q <= 32'sd0;
      vel_q <= 16'h0000;
      acc_q <= 16'h0000;
      tick_q <= 16'h0000;
      step_out <= 1'b0;
      dir_out <= 1'b1;
      drive_enable <= 1'b0;
      homing <= 1'b0;
      seek_done <= 1'b0;
      smooth_freq <= 12'h000;
      smooth_active <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      mot_q <= mot_d;
      freq_q <= freq_d;
      thresh_q <= thresh_d;
      sel_q <= sel_d;
      cond_q <= cond_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
      state_q <= state_d;
      dir_q <= dir_d;
      seek_dir_q <= seek_dir_d;
      home_q <= home_d;
      pos_q <= pos_d;
      vel_q <= vel_d;
      acc_q <= acc_d;
      tick_q <= tick_d;
      step_out <= step_d;
      dir_out <= dir_q;
      drive_enable <= en_d;
      homing <= state_d != hse_pkg::ST_IDLE;
      seek_done <= done_d;
      smooth_freq <= smooth_d;
      smooth_active <= smooth_act_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_start_sets_homing: assert property (start |=> homing && status[hse_pkg::ST_HOMING])
    else $error("homing flag not raised after seek start");
  a_seek_direction: assert property (start |=> dir_q == !$past(mot_q.move_length[31]))
    else $error("seek direction does not follow move length sign");
  a_home_latch: assert property ((state_q == hse_pkg::ST_SEEK) && hit
      |=> (home_q == $past(pos_q)) && (state_q == hse_pkg::ST_BRAKE))
    else $error("home position not latched on detection");
  a_brake_no_speedup: assert property ((state_q == hse_pkg::ST_BRAKE) |=> vel_q <= $past(vel_q))
    else $error("motor sped up while braking");
  a_limit_turns: assert property ((state_q == hse_pkg::ST_SEEK) && !hit && fwd_lim
      |=> state_q == hse_pkg::ST_TURN)
    else $error("limit before home did not reverse");
  a_ramp_up: assert property ((state_q == hse_pkg::ST_SEEK) && tick
      && (vel_q < mot_q.cruise_rate) && (mot_q.ramp_up_rate != 16'h0000)
      |=> vel_q > $past(vel_q))
    else $error("speed did not ramp toward cruise rate");
  a_return_done: assert property ((state_q == hse_pkg::ST_RETURN) && (pos_q == home_q)
      |=> seek_done && !homing ##1 !seek_done)
    else $error("seek did not finish at latched position");
  a_speed_mode_free: assert property (hse_pkg::is_speed_mode(cfg_q.control_mode)
      |-> cfg_q.en_usage == hse_pkg::USE_FREE)
    else $error("enable usage kept under speed change mode");
  a_gate_owner: assert property (!(hse_pkg::owns_gate(cfg_q.fault_clear_usage)
      && hse_pkg::owns_gate(cfg_q.en_usage)))
    else $error("gate input has two owners");
  a_freq_range: assert property (smooth_active |-> smooth_freq <= hse_pkg::FREQ_MAX
      && $past(cfg_q.control_mode) == hse_pkg::CM_PULSE_DIR)
    else $error("smoothing filter applied outside pulse mode or range");

  c_seek_start: cover property (start);
  c_seek_done: cover property (seek_done);
  c_limit_turn: cover property ((state_q == hse_pkg::ST_TURN) ##[1:1000] (state_q == hse_pkg::ST_REV));
  c_edge_home: cover property ((state_q == hse_pkg::ST_SEEK) && hit && (cond_q == hse_pkg::COND_F));

endmodule

// *** hse_axis_model.sv ***
// axis and sensor model on the motor side of the home seek block
// assumes step_out pulses one cycle per step, dir_out valid with it
`timescale 1ns/1ps

module hse_axis_model #(
  parameter int HOME_AT = 40
) (
  input wire logic clk_sys,
  input wire logic step_out,
  input wire logic dir_out,
  input wire logic cw_lvl,
  output logic pulse_input,
  output logic rotation_sense_input,
  output logic gate_input,
  output int pos
);
  // ----------------------------------------------------------------
  // shaft position and flag
  // ----------------------------------------------------------------
  initial pos = 0;
  always @(posedge clk_sys) begin
    if (step_out === 1'h1) begin
      pos <= dir_out ? pos + 1 : pos - 1;
    end
  end
  // unwired points read open; the flag closes once the shaft passes it
  assign pulse_input = cw_lvl;
  assign rotation_sense_input = 1'h1;
  assign gate_input = (pos >= HOME_AT) ? 1'h0 : 1'h1;
endmodule

// *** tb_top.sv ***
// self-checking bench for the home seek and gate enable block
// assumes the axis model closes the gate flag at step 40
`timescale 1ns/1ps

module tb_top;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} hse_row_t;
  logic clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, cw_lvl = 1, er;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, hm;
  logic pready, pslverr, pulse_input, rotation_sense_input, gate_input, step_out, dir_out;
  logic drive_enable, homing, seek_done, smooth_active;
  logic [11:0] smooth_freq;
  logic [11:0] analog_input = 0;
  logic [3:0] io_point_is_input = 4'hf;
  int err_count = 0, num_checks = 0, pos, n;
  hse_row_t rows[20] = '{
    '{1'h0, hse_pkg::REG_SMOOTH, 32'h0, 32'h9c4, 1'h0},
    '{1'h1, hse_pkg::REG_SMOOTH, 32'h9c5, 32'h0, 1'h1},
    '{1'h1, hse_pkg::REG_SMOOTH, 32'h1f4, 32'h0, 1'h0},
    '{1'h0, hse_pkg::REG_SMOOTH, 32'h0, 32'h1f4, 1'h0},
    '{1'h0, 8'h30, 32'h0, 32'h0, 1'h1},
    '{1'h1, hse_pkg::REG_POS, 32'h0, 32'h0, 1'h1},
    '{1'h1, hse_pkg::REG_ENABLE, 32'h30, 32'h0, 1'h1},
    '{1'h1, hse_pkg::REG_ENABLE, 32'h21, 32'h0, 1'h1},
    '{1'h1, hse_pkg::REG_ENABLE, 32'h11, 32'h0, 1'h0},
    '{1'h0, hse_pkg::REG_ENABLE, 32'h0, 32'h0b11, 1'h0},
    '{1'h1, hse_pkg::REG_ENABLE, 32'h31, 32'h0, 1'h0},
    '{1'h1, hse_pkg::REG_CFG, 32'h30d03, 32'h0, 1'h0},
    '{1'h0, hse_pkg::REG_ENABLE, 32'h0, 32'h2133, 1'h0},
    '{1'h1, hse_pkg::REG_ENABLE, 32'h31, 32'h0, 1'h1},
    '{1'h1, hse_pkg::REG_CFG, 32'h30703, 32'h0, 1'h0},
    '{1'h1, hse_pkg::REG_ENABLE, 32'h31, 32'h0, 1'h0},
    '{1'h1, hse_pkg::REG_CFG, 32'h10703, 32'h0, 1'h0},
    '{1'h0, hse_pkg::REG_ENABLE, 32'h0, 32'h2133, 1'h0},
    '{1'h1, hse_pkg::REG_ENABLE, 32'h31, 32'h0, 1'h0},
    '{1'h0, hse_pkg::REG_CFG, 32'h0, 32'h30703, 1'h0}};

  hse_top dut_u (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pulse_input(pulse_input), .rotation_sense_input(rotation_sense_input),
    .gate_input(gate_input), .analog_input(analog_input), .io_point_is_input(io_point_is_input),
    .step_out(step_out), .dir_out(dir_out), .drive_enable(drive_enable), .homing(homing),
    .seek_done(seek_done), .smooth_freq(smooth_freq), .smooth_active(smooth_active));
  hse_axis_model axis_u (.clk_sys(clk_sys), .step_out(step_out), .dir_out(dir_out),
    .cw_lvl(cw_lvl), .pulse_input(pulse_input), .rotation_sense_input(rotation_sense_input),
    .gate_input(gate_input), .pos(pos));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys);
      if (pready === 1'h1) break;
    end
    rd = prdata;
    er = pslverr;
    if (k == 50) chk(32'h1, 32'h0);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic run_rows(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk(rd, rows[i].x);
      chk({31'h0, er}, {31'h0, rows[i].e});
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------------------------------
  initial forever #5 clk_sys = ~clk_sys;

  initial begin
    repeat (40000) @(posedge clk_sys);
    err_count++;
    print_verdict;
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    resetn <= 1'h1;
    run_rows(0, 9);
    chk(smooth_freq, 12'h1f4);
    chk(smooth_active, 1'h1);
    // enable follows point 1 edges late, so 6 leaves margin
    repeat (6) @(posedge clk_sys);
    chk(drive_enable, 1'h1);
    cw_lvl <= 1'h0;
    repeat (6) @(posedge clk_sys);
    chk(drive_enable, 1'h0);
    apb(1'h1, hse_pkg::REG_ENABLE, 32'h12);
    repeat (6) @(posedge clk_sys);
    chk(drive_enable, 1'h1);
    cw_lvl <= 1'h1;
    run_rows(10, 11);
    repeat (2) @(posedge clk_sys);
    chk(smooth_active, 1'h0);
    chk(smooth_freq, 12'h000);
    run_rows(12, 19);
    apb(1'h1, hse_pkg::REG_CRUISE, 32'h1000);
    apb(1'h1, hse_pkg::REG_RAMP_UP, 32'h1000);
    apb(1'h1, hse_pkg::REG_RAMP_DN, 32'h1000);
    apb(1'h1, hse_pkg::REG_LENGTH, 32'h64);
    apb(1'h1, hse_pkg::REG_SEEK, 32'h23);
    repeat (3) @(posedge clk_sys);
    chk(homing, 1'h1);
    apb(1'h0, hse_pkg::REG_STATUS, 32'h0);
    chk(rd[10], 1'h1);
    apb(1'h1, hse_pkg::REG_SEEK, 32'h23);
    chk(er, 1'h1);
    for (n = 0; n < 20000 && seek_done !== 1'h1; n++) @(posedge clk_sys);
    chk(seek_done, 1'h1);
    chk(homing, 1'h0);
    apb(1'h0, hse_pkg::REG_HOME, 32'h0);
    hm = rd;
    chk({31'h0, $signed(hm) >= 40}, 32'h1);
    apb(1'h0, hse_pkg::REG_POS, 32'h0);
    chk(rd, hm);
    chk(32'(pos), hm);
    io_point_is_input <= 4'hb;
    apb(1'h1, hse_pkg::REG_ENABLE, 32'h31);
    chk(er, 1'h1);
    io_point_is_input <= 4'hf;
    // limits active high: the ccw pin idles high, so each reversal is short
    apb(1'h1, hse_pkg::REG_CFG, 32'h30702);
    apb(1'h1, hse_pkg::REG_SEEK, 32'h11);
    chk(er, 1'h1);
    apb(1'h1, hse_pkg::REG_SEEK, 32'h10);
    for (n = 0; n < 300 && dir_out !== 1'h1; n++) @(posedge clk_sys);
    chk(dir_out, 1'h1);
    for (n = 0; n < 300 && dir_out !== 1'h0; n++) @(posedge clk_sys);
    chk(dir_out, 1'h0);
    cw_lvl <= 1'h0;
    analog_input <= 12'h001;
    for (n = 0; n < 20000 && seek_done !== 1'h1; n++) @(posedge clk_sys);
    chk(seek_done, 1'h1);
    apb(1'h0, hse_pkg::REG_HOME, 32'h0);
    hm = rd;
    apb(1'h0, hse_pkg::REG_POS, 32'h0);
    chk(rd, hm);
    print_verdict;
  end
endmodule
